// >>> bench/srcl_rom_model.sv
// Behavioural two-wire serial ROM that answers random and sequential reads
`timescale 1ns/100ps
module srcl_rom_model #(
	parameter logic [6:0] DEV = 7'h50
) (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic mute,
	input  wire logic slow,
	output logic      scl_oe_n,
	output logic      sda_oe_n
);
	logic [7:0] mem [0:31];
	logic [7:0] sh;
	logic [4:0] ptr;
	logic       rd, go, nak;
	int         n, k;
	initial begin
		scl_oe_n = 1;
		sda_oe_n = 1;
		go = 0;
		rd = 0;
		nak = 0;
		ptr = 0;
	end
	// The fall of the clock that closes a start is not a bit
	always @(negedge sda) if (scl) begin
		n = -1;
		k = 0;
		rd = 0;
		go = 1;
	end
	always @(posedge sda) if (scl) go = 0;
	always @(posedge scl) if (go) begin
		if (n < 8) sh = {sh[6:0], sda};
		else nak = sda;
	end
	// Mute refuses the control byte so the abort path can be reached
	always @(negedge scl) if (go) begin
		if (n == 7) begin
			n = 8;
			sda_oe_n = rd || (k == 0 && (sh[7:1] != DEV || mute));
		end else if (n == 8) begin
			n = 0;
			k = k + 1;
			if (rd) begin
				ptr = ptr + 5'(!nak);
				go = !nak;
			end
			if (k == 2 && !rd) ptr = sh[4:0];
			if (k == 1) rd = sh[0];
			sda_oe_n = !(go && rd) || mem[ptr][7];
		end else begin
			n = n + 1;
			if (rd) sda_oe_n = mem[ptr][7 - n];
		end
	end
	// Stretches every low phase, like a ROM still busy
	always @(negedge scl) if (slow) begin
		scl_oe_n = 0;
		#2000 scl_oe_n = 1;
	end
endmodule

// >>> bench/srcl_top_chk.sv
// Assertion checker for the serial ROM configuration loader
`timescale 1ns/100ps
module srcl_top_chk
	import srcl_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
) (
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic        SCL_OE_N,
	input wire logic        SDA_OE_N,
	input wire logic        PCI_TGT_ACC,
	input wire logic        PCI_RETRY,
	input wire logic        LOAD_BUSY,
	input wire logic [15:0] MLMG_FIELD,
	input wire logic [15:0] LINK_ENH_FIELD,
	input wire logic [31:0] GUID_HI,
	input wire logic [31:0] GUID_LO
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	a_retry_busy: assert property (PCI_RETRY == (LOAD_BUSY && PCI_TGT_ACC))
		else $error("retry not tied to busy and access");
	a_load_start: assert property ($fell(SYS_RST) |=> LOAD_BUSY)
		else $error("load did not start after reset");
	a_busy_hold: assert property ($rose(LOAD_BUSY) |-> LOAD_BUSY[*8])
		else $error("load ended too soon");
	a_start_cond: assert property ($rose(LOAD_BUSY) |-> ##[0:40] (!SDA_OE_N && SCL_OE_N))
		else $error("no start condition");
	a_idle_free: assert property (!LOAD_BUSY |-> SCL_OE_N && SDA_OE_N)
		else $error("wire held while idle");
	a_fields_hold: assert property (!LOAD_BUSY |=> $stable({MLMG_FIELD, GUID_HI, GUID_LO}))
		else $error("field changed outside a load");
	a_link_rsvd: assert property ((LINK_ENH_FIELD & 16'hcf79) == 16'h0000)
		else $error("unmapped link bit set");
	a_mlmg_width: assert property (MLMG_FIELD[15:8] == 8'h00)
		else $error("latency field upper byte set");
endmodule
bind srcl_top srcl_top_chk #(.TICKS(TICKS)) u_chk (
	.CLK(CLK),
	.SYS_RST(SYS_RST),
	.SCL_OE_N(SCL_OE_N),
	.SDA_OE_N(SDA_OE_N),
	.PCI_TGT_ACC(PCI_TGT_ACC),
	.PCI_RETRY(PCI_RETRY),
	.LOAD_BUSY(LOAD_BUSY),
	.MLMG_FIELD(MLMG_FIELD),
	.LINK_ENH_FIELD(LINK_ENH_FIELD),
	.GUID_HI(GUID_HI),
	.GUID_LO(GUID_LO)
);

// >>> bench/test_srcl_top.sv
// Self-checking bench for the serial ROM configuration loader
`timescale 1ns/100ps
module test_srcl_top;
	import srcl_pkg::*;
	logic        CLK, SYS_RST, HSEL, HWRITE, PCI_TGT_ACC, mute, slow;
	logic [31:0] HADDR, HWDATA, HRDATA, GUID_HI, GUID_LO;
	logic [1:0]  HTRANS;
	logic [15:0] MLMG_FIELD, VENDOR_FIELD, SUBSYS_FIELD, LINK_ENH_FIELD;
	logic        HREADYOUT, SCL_OE_N, SDA_OE_N, PCI_RETRY, LOAD_BUSY, PHY_PROGRAMMING_ALLOW;
	logic        HRESP;
	wire         scl, sda, m_scl, m_sda;
	int          n_mismatch, total_checks;
	assign scl = SCL_OE_N & m_scl;
	assign sda = SDA_OE_N & m_sda;
	srcl_top #(.TICKS(2)) dut (
		.CLK(CLK),
		.SYS_RST(SYS_RST),
		.HSEL(HSEL),
		.HADDR(HADDR),
		.HTRANS(HTRANS),
		.HWRITE(HWRITE),
		.HSIZE(3'b010),
		.HWDATA(HWDATA),
		.HREADY(HREADYOUT),
		.HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT),
		.HRESP(HRESP),
		.SCL_IN(scl),
		.SCL_OUT(),
		.SCL_OE_N(SCL_OE_N),
		.SDA_IN(sda),
		.SDA_OUT(),
		.SDA_OE_N(SDA_OE_N),
		.PCI_TGT_ACC(PCI_TGT_ACC),
		.PCI_RETRY(PCI_RETRY),
		.LOAD_BUSY(LOAD_BUSY),
		.MLMG_FIELD(MLMG_FIELD),
		.VENDOR_FIELD(VENDOR_FIELD),
		.SUBSYS_FIELD(SUBSYS_FIELD),
		.PHY_PROGRAMMING_ALLOW(PHY_PROGRAMMING_ALLOW),
		.LINK_ENH_FIELD(LINK_ENH_FIELD),
		.GUID_HI(GUID_HI),
		.GUID_LO(GUID_LO)
	);
	srcl_rom_model rom (
		.scl(scl),
		.sda(sda),
		.mute(mute),
		.slow(slow),
		.scl_oe_n(m_scl),
		.sda_oe_n(m_sda)
	);
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		HSEL <= 1;
		HTRANS <= 2'b10;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 0;
		HTRANS <= 2'b00;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		ahb(0, a, 0);
		chk($sformatf("reg %h", a), e, HRDATA);
		chk("hresp", 0, {31'h0, HRESP});
	endtask
	task automatic fill(input logic [7:0] s, input logic [7:0] b5, input logic [7:0] b16);
		for (int i = 0; i < 32; i++) rom.mem[i] = 8'(i * 29) ^ s;
		rom.mem[5] = b5;
		rom.mem[16] = b16;
	endtask
	// Waits a few edges first so a just-requested reload has begun
	task automatic wait_idle;
		int t;
		t = 0;
		repeat (3) @(posedge CLK);
		while (LOAD_BUSY !== 1'b0 && t < 20000) begin
			@(posedge CLK);
			t++;
		end
		chk("busy", 0, LOAD_BUSY);
	endtask
	task automatic fields;
		logic [7:0] m [0:16];
		for (int i = 0; i < 17; i++) m[i] = rom.mem[i];
		@(negedge CLK);
		chk("mlmg", {24'h0, m[0]}, {16'h0, MLMG_FIELD});
		chk("vendor", {16'h0, m[2], m[1]}, {16'h0, VENDOR_FIELD});
		chk("subsys", {16'h0, m[4], m[3]}, {16'h0, SUBSYS_FIELD});
		chk("phy", {31'h0, m[5][6]}, {31'h0, PHY_PROGRAMMING_ALLOW});
		chk("guid hi", {m[10], m[9], m[8], m[7]}, GUID_HI);
		chk("guid lo", {m[14], m[13], m[12], m[11]}, GUID_LO);
		@(posedge CLK);
		rreg(REG_HCC, {8'h0, m[5][6], 23'h0});
		rreg(REG_LEC, {18'h0, m[16][5:4], 4'h0, m[5][7], 4'h0, m[5][2:1], 1'b0});
		rreg(REG_MINI, {24'h0, m[6]});
	endtask
	initial begin
		CLK = 0;
		forever #50 CLK = ~CLK;
	end
	initial begin
		#4000000;
		n_mismatch++;
		conclude();
	end
	initial begin
		{SYS_RST, HSEL, HWRITE, PCI_TGT_ACC, mute, slow} = 6'b100000;
		{HADDR, HWDATA, HTRANS} = 0;
		fill(8'h00, 8'hbf, 8'h30);
		repeat (6) @(posedge CLK);
		SYS_RST <= 0;
		PCI_TGT_ACC <= 1;
		@(posedge CLK);
		@(negedge CLK);
		chk("busy", 1, LOAD_BUSY);
		chk("retry", 1, PCI_RETRY);
		@(posedge CLK);
		rreg(REG_STATUS, 32'h1);
		wait_idle();
		chk("retry", 0, PCI_RETRY);
		fields();
		rreg(REG_STATUS, 32'h2);
		rreg(8'h40, 0);
		rreg(REG_CTRL, 0);
		fill(8'h5a, 8'h40, 8'hcf);
		slow <= 1;
		ahb(1, REG_CTRL, 1);
		wait_idle();
		fields();
		mute <= 1;
		ahb(1, REG_CTRL, 1);
		wait_idle();
		rreg(REG_STATUS, 32'h4);
		fields();
		conclude();
	end
endmodule

// >>> src/srcl_div.sv
// Quarter-bit enable pulse divider
`timescale 1ns/100ps
module srcl_div #(
	parameter int COUNT = 25
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic en,
	output logic      tick
);
	logic [15:0] cnt_ff;

	always_ff @(posedge clk) begin
		if (rst || !en) begin
			cnt_ff <= 16'h0000;
			tick   <= 1'b0;
		end else if (cnt_ff == 16'(COUNT - 1)) begin
			cnt_ff <= 16'h0000;
			tick   <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
			tick   <= 1'b0;
		end
	end
endmodule

// >>> src/srcl_pkg.sv
// Constants shared by the serial ROM configuration loader
package srcl_pkg;
	// Clock and two-wire bus timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int TICK_CYCLES   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

	// Two-wire device address and control bytes
	localparam logic [6:0] ROM_DEV_ADDR = 7'h50;
	localparam logic [7:0] ROM_START    = 8'h00;

	// ROM byte indexes
	localparam logic [4:0] ROM_MLMG     = 5'h00;
	localparam logic [4:0] ROM_VEND_LO  = 5'h01;
	localparam logic [4:0] ROM_VEND_HI  = 5'h02;
	localparam logic [4:0] ROM_SUBS_LO  = 5'h03;
	localparam logic [4:0] ROM_SUBS_HI  = 5'h04;
	localparam logic [4:0] ROM_LINK_LO  = 5'h05;
	localparam logic [4:0] ROM_MINI_PTR = 5'h06;
	localparam logic [4:0] ROM_GHI_0    = 5'h07;
	localparam logic [4:0] ROM_GHI_3    = 5'h0a;
	localparam logic [4:0] ROM_GLO_0    = 5'h0b;
	localparam logic [4:0] ROM_GLO_3    = 5'h0e;
	localparam logic [4:0] ROM_LINK_HI  = 5'h10;
	localparam logic [4:0] ROM_LAST     = 5'h10;

	// Bit positions
	localparam int ROM_PHY_BIT   = 6;
	localparam int HCC_PHY_BIT   = 23;
	localparam int LEC_UNFAIR    = 7;
	localparam int LEC_IDLE      = 2;
	localparam int LEC_ACCEL     = 1;
	localparam int LEC_THR_HI    = 13;
	localparam int LEC_THR_LO    = 12;
	localparam int ROM_THR_HI    = 5;
	localparam int ROM_THR_LO    = 4;

	// Register map, byte addresses
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_CTRL    = 8'h04;
	localparam logic [7:0] REG_MLMG    = 8'h08;
	localparam logic [7:0] REG_VENDOR  = 8'h0c;
	localparam logic [7:0] REG_SUBSYS  = 8'h10;
	localparam logic [7:0] REG_HCC     = 8'h14;
	localparam logic [7:0] REG_LEC     = 8'h18;
	localparam logic [7:0] REG_GUID_HI = 8'h1c;
	localparam logic [7:0] REG_GUID_LO = 8'h20;
	localparam logic [7:0] REG_MINI    = 8'h24;

	// Field positions and reset values
	localparam int STAT_BUSY   = 0;
	localparam int STAT_DONE   = 1;
	localparam int STAT_ERR    = 2;
	localparam int CTRL_RELOAD = 0;
	localparam logic [15:0] RST_16 = 16'h0000;
	localparam logic [31:0] RST_32 = 32'h0000_0000;

	typedef enum logic [7:0] {
		ST_IDLE    = 8'h01,
		ST_START   = 8'h02,
		ST_SEND    = 8'h04,
		ST_SACK    = 8'h08,
		ST_RESTART = 8'h10,
		ST_RECV    = 8'h20,
		ST_MACK    = 8'h40,
		ST_STOP    = 8'h80
	} srcl_state_e;

	typedef enum logic [2:0] {
		PH_DEVW = 3'h1,
		PH_ADDR = 3'h2,
		PH_DEVR = 3'h4
	} srcl_phase_e;
endpackage

// >>> src/srcl_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module srcl_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;

	// Idle bus level is high, so reset to high
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= '1;
			q       <= '1;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule

// >>> src/srcl_top.sv
// Serial ROM configuration loader with AHB-Lite status registers
// Contract
// R1: Read serial ROM after reset, load registers
// R2: Retry every PCI target access while loading
// R3: ROM byte 00h into latency/grant field
// R4: Vendor and subsystem IDs, low byte first
// R5: Byte 05h bit 6 to control bit 23
// R6: Byte 05h bits 7,2,1 to link enhancement
// R7: Byte 10h two bits to bits 13,12
// R8: GUID high/low from bytes 07h-0Eh, lsbyte first
// R9: Ascending reads; done after last byte stored
`timescale 1ns/100ps
module srcl_top
	import srcl_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = ROM_DEV_ADDR,
	parameter int         TICKS    = TICK_CYCLES
) (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        SCL_IN,
	output logic             SCL_OUT,
	output logic             SCL_OE_N,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE_N,
	input  wire logic        PCI_TGT_ACC,
	output logic             PCI_RETRY,
	output logic             LOAD_BUSY,
	output logic      [15:0] MLMG_FIELD,
	output logic      [15:0] VENDOR_FIELD,
	output logic      [15:0] SUBSYS_FIELD,
	output logic             PHY_PROGRAMMING_ALLOW,
	output logic      [15:0] LINK_ENH_FIELD,
	output logic      [31:0] GUID_HI,
	output logic      [31:0] GUID_LO
);
	srcl_state_e state_ff;
	srcl_phase_e phase_ff;
	logic [1:0]  q_ff;
	logic [2:0]  bit_ff;
	logic [7:0]  sh_ff;
	logic [4:0]  idx_ff;
	logic        scl_low_ff;
	logic        sda_low_ff;
	logic        start_pend_ff;
	logic        done_ff;
	logic        err_ff;
	logic [7:0]  mini_ff;
	logic        wr_ff;
	logic [7:0]  waddr_ff;
	logic [31:0] hrdata_ff;
	logic        scl_s;
	logic        sda_s;
	logic        tick;
	logic        busy;
	logic        step;
	logic        store;
	logic [7:0]  store_byte;
	logic        addr_ph;
	logic        reload;

	// Lane write into a 32-bit word
	function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] lane,
		input logic [7:0] b);
		logic [31:0] r;
		r = w;
		r[8*lane +: 8] = b;
		return r;
	endfunction

	// Register read mux
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == REG_STATUS) begin
			r[STAT_BUSY] = busy;
			r[STAT_DONE] = done_ff;
			r[STAT_ERR]  = err_ff;
		end else if (a == REG_MLMG) begin
			r[15:0] = MLMG_FIELD;
		end else if (a == REG_VENDOR) begin
			r[15:0] = VENDOR_FIELD;
		end else if (a == REG_SUBSYS) begin
			r[15:0] = SUBSYS_FIELD;
		end else if (a == REG_HCC) begin
			r[HCC_PHY_BIT] = PHY_PROGRAMMING_ALLOW;
		end else if (a == REG_LEC) begin
			r[15:0] = LINK_ENH_FIELD;
		end else if (a == REG_GUID_HI) begin
			r = GUID_HI;
		end else if (a == REG_GUID_LO) begin
			r = GUID_LO;
		end else if (a == REG_MINI) begin
			r[7:0] = mini_ff;
		end
		return r;
	endfunction

	srcl_sync #(
		.WIDTH (2)
	) u_sync (
		.clk (CLK),
		.rst (SYS_RST),
		.d   ({SCL_IN, SDA_IN}),
		.q   ({scl_s, sda_s})
	);

	srcl_div #(
		.COUNT (TICKS)
	) u_div (
		.clk  (CLK),
		.rst  (SYS_RST),
		.en   (busy),
		.tick (tick)
	);

	assign busy = (state_ff != ST_IDLE);
	// Any quarter after a release waits for the wire, else start/stop land in a stretch
	assign step = tick && !(!scl_low_ff && !scl_s);
	assign store = step && (state_ff == ST_RECV) && (q_ff == 2'd3) && (bit_ff == 3'd7);
	assign store_byte = {sh_ff[6:0], sda_s};

	// Open-drain pins only ever pull low
	assign SCL_OUT  = 1'b0;
	assign SDA_OUT  = 1'b0;
	assign SCL_OE_N = !scl_low_ff;
	assign SDA_OE_N = !sda_low_ff;

	assign LOAD_BUSY = busy;
	assign PCI_RETRY = busy && PCI_TGT_ACC; // see R2

	// Two-wire sequence: write pointer, restart, sequential read
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_ff   <= ST_IDLE;
			phase_ff   <= PH_DEVW;
			q_ff       <= 2'd0;
			bit_ff     <= 3'd0;
			sh_ff      <= 8'h00;
			idx_ff     <= 5'h00;
			scl_low_ff <= 1'b0;
			sda_low_ff <= 1'b0;
		end else if (state_ff == ST_IDLE) begin
			q_ff <= 2'd0;
			if (start_pend_ff) begin
				state_ff <= ST_START; // see R1
				idx_ff   <= ROM_MLMG;
				phase_ff <= PH_DEVW;
			end
		end else if (step) begin
			q_ff <= q_ff + 2'd1;
			case (state_ff)
				ST_START, ST_RESTART: begin
					if (q_ff == 2'd0) begin
						scl_low_ff <= 1'b1;
						sda_low_ff <= 1'b0;
					end else if (q_ff == 2'd1) begin
						scl_low_ff <= 1'b0;
					end else if (q_ff == 2'd2) begin
						sda_low_ff <= 1'b1;
					end else begin
						scl_low_ff <= 1'b1;
						bit_ff     <= 3'd0;
						state_ff   <= ST_SEND;
						sh_ff      <= (state_ff == ST_START) ? {DEV_ADDR, 1'b0}
							: {DEV_ADDR, 1'b1};
					end
				end
				ST_SEND: begin
					if (q_ff == 2'd0) begin
						scl_low_ff <= 1'b1;
						sda_low_ff <= !sh_ff[7];
					end else if (q_ff == 2'd2) begin
						scl_low_ff <= 1'b0;
					end else if (q_ff == 2'd3) begin
						sh_ff  <= {sh_ff[6:0], 1'b0};
						bit_ff <= bit_ff + 3'd1;
						if (bit_ff == 3'd7) begin
							state_ff <= ST_SACK;
						end
					end
				end
				ST_SACK: begin
					if (q_ff == 2'd0) begin
						scl_low_ff <= 1'b1;
						sda_low_ff <= 1'b0;
					end else if (q_ff == 2'd2) begin
						scl_low_ff <= 1'b0;
					end else if (q_ff == 2'd3) begin
						if (sda_s) begin
							state_ff <= ST_STOP;
						end else if (phase_ff == PH_DEVW) begin
							phase_ff <= PH_ADDR;
							sh_ff    <= ROM_START; // see R9
							state_ff <= ST_SEND;
						end else if (phase_ff == PH_ADDR) begin
							phase_ff <= PH_DEVR;
							state_ff <= ST_RESTART;
						end else begin
							state_ff <= ST_RECV;
						end
					end
				end
				ST_RECV: begin
					if (q_ff == 2'd0) begin
						scl_low_ff <= 1'b1;
						sda_low_ff <= 1'b0;
					end else if (q_ff == 2'd2) begin
						scl_low_ff <= 1'b0;
					end else if (q_ff == 2'd3) begin
						sh_ff  <= store_byte;
						bit_ff <= bit_ff + 3'd1;
						if (bit_ff == 3'd7) begin
							state_ff <= ST_MACK;
						end
					end
				end
				ST_MACK: begin
					if (q_ff == 2'd0) begin
						scl_low_ff <= 1'b1;
						sda_low_ff <= (idx_ff != ROM_LAST); // see R9
					end else if (q_ff == 2'd2) begin
						scl_low_ff <= 1'b0;
					end else if (q_ff == 2'd3) begin
						if (idx_ff == ROM_LAST) begin
							state_ff <= ST_STOP;
						end else begin
							idx_ff   <= idx_ff + 5'h01; // see R9
							state_ff <= ST_RECV;
						end
					end
				end
				ST_STOP: begin
					if (q_ff == 2'd0) begin
						scl_low_ff <= 1'b1;
						sda_low_ff <= 1'b1;
					end else if (q_ff == 2'd2) begin
						scl_low_ff <= 1'b0;
					end else if (q_ff == 2'd3) begin
						sda_low_ff <= 1'b0;
						state_ff   <= ST_IDLE; // see R9
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Load request: at reset release, then on software reload
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			start_pend_ff <= 1'b1; // see R1
		end else if (reload) begin
			start_pend_ff <= 1'b1;
		end else if (state_ff == ST_IDLE) begin
			start_pend_ff <= 1'b0;
		end
	end

	// Completion and missing-acknowledge flags
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			done_ff <= 1'b0;
			err_ff  <= 1'b0;
		end else if ((state_ff == ST_IDLE) && start_pend_ff) begin
			done_ff <= 1'b0;
			err_ff  <= 1'b0;
		end else if (step && (q_ff == 2'd3)) begin
			if ((state_ff == ST_SACK) && sda_s) begin
				err_ff <= 1'b1;
			end
			if ((state_ff == ST_MACK) && (idx_ff == ROM_LAST)) begin
				done_ff <= 1'b1; // see R9
			end
		end
	end

	// Loaded configuration fields
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			MLMG_FIELD            <= RST_16;
			VENDOR_FIELD          <= RST_16;
			SUBSYS_FIELD          <= RST_16;
			PHY_PROGRAMMING_ALLOW <= 1'b0;
			LINK_ENH_FIELD        <= RST_16;
			GUID_HI               <= RST_32;
			GUID_LO               <= RST_32;
			mini_ff               <= 8'h00;
		end else if (store) begin
			if (idx_ff == ROM_MLMG) begin
				MLMG_FIELD <= {8'h00, store_byte}; // see R3
			end else if (idx_ff == ROM_VEND_LO) begin
				VENDOR_FIELD[7:0] <= store_byte; // see R4
			end else if (idx_ff == ROM_VEND_HI) begin
				VENDOR_FIELD[15:8] <= store_byte; // see R4
			end else if (idx_ff == ROM_SUBS_LO) begin
				SUBSYS_FIELD[7:0] <= store_byte; // see R4
			end else if (idx_ff == ROM_SUBS_HI) begin
				SUBSYS_FIELD[15:8] <= store_byte; // see R4
			end else if (idx_ff == ROM_LINK_LO) begin
				PHY_PROGRAMMING_ALLOW      <= store_byte[ROM_PHY_BIT]; // see R5
				LINK_ENH_FIELD[LEC_UNFAIR] <= store_byte[LEC_UNFAIR]; // see R6
				LINK_ENH_FIELD[LEC_IDLE]   <= store_byte[LEC_IDLE]; // see R6
				LINK_ENH_FIELD[LEC_ACCEL]  <= store_byte[LEC_ACCEL]; // see R6
			end else if (idx_ff == ROM_MINI_PTR) begin
				mini_ff <= store_byte;
			end else if ((idx_ff >= ROM_GHI_0) && (idx_ff <= ROM_GHI_3)) begin
				GUID_HI <= put_byte(GUID_HI, 2'(idx_ff - ROM_GHI_0), store_byte); // see R8
			end else if ((idx_ff >= ROM_GLO_0) && (idx_ff <= ROM_GLO_3)) begin
				GUID_LO <= put_byte(GUID_LO, 2'(idx_ff - ROM_GLO_0), store_byte); // see R8
			end else if (idx_ff == ROM_LINK_HI) begin
				LINK_ENH_FIELD[LEC_THR_HI] <= store_byte[ROM_THR_HI]; // see R7
				LINK_ENH_FIELD[LEC_THR_LO] <= store_byte[ROM_THR_LO]; // see R7
			end
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign HRDATA    = hrdata_ff;
	assign addr_ph   = HSEL && HTRANS[1] && HREADY;
	// Reload while busy is dropped to keep one sequence on the wires
	assign reload    = wr_ff && (waddr_ff == REG_CTRL) && HWDATA[CTRL_RELOAD] && !busy;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			wr_ff    <= 1'b0;
			waddr_ff <= 8'h00;
		end else if (HREADY) begin
			wr_ff    <= addr_ph && HWRITE;
			waddr_ff <= HADDR[7:0];
		end
	end

	// Read data captured in the address phase
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			hrdata_ff <= RST_32;
		end else if (addr_ph && !HWRITE) begin
			hrdata_ff <= (HADDR[31:8] == 24'h000000) ? rd_mux(HADDR[7:0]) : RST_32;
		end
	end
endmodule
